// >>> design/jtbs_bscan_chain.sv
// Boundary cell shift stage and falling edge update latches
module jtbs_bscan_chain #(
	parameter int LEN = 24
) (
	// Test clock and reset
	input wire logic tck,
	input wire logic trst_b,
	// TAP side
	jtbs_chain_if.chain bc
);
	import jtbs_pkg::*;

	typedef struct packed {
		logic [LEN-1:0] sh;
	} jtbs_shift_t;

	typedef struct packed {
		logic [LEN-1:0] upd;
	} jtbs_upd_t;

	jtbs_shift_t q;
	jtbs_shift_t next_q;
	jtbs_upd_t u;
	jtbs_upd_t next_u;

	// ----------------------------------------
	// Capture and shift
	// ----------------------------------------
	always_comb
	begin
		next_q = q;
		if (bc.captureEn)
			next_q.sh = bc.capVal;
		else if (bc.shiftEn)
			next_q.sh = {bc.tdi, q.sh[LEN-1:1]};
	end

	always_ff @(posedge tck or negedge trst_b)
	begin
		if (!trst_b)
			q <= '0;
		else
			q <= next_q;
	end

	// ----------------------------------------
	// Update latches
	// ----------------------------------------
	always_comb
	begin
		next_u = u;
		if (bc.updateEn)
			next_u.upd = q.sh;
	end

	always_ff @(negedge tck or negedge trst_b)
	begin
		if (!trst_b)
			u <= '0;
		else
			u <= next_u;
	end

	assign bc.chainOut = q.sh[0];
	assign bc.updVal = u.upd;
endmodule : jtbs_bscan_chain

// >>> design/jtbs_cfg.svh
// Constants for the test access port and boundary chain
`ifndef JTBS_CFG_SVH
`define JTBS_CFG_SVH
`define JTBS_IR_WIDTH 6
`define JTBS_IR_CAPTURE 6'h2D
`define JTBS_OP_EXTEST 6'h00
`define JTBS_OP_SAMPLE 6'h01
`define JTBS_OP_IDCODE 6'h02
`define JTBS_OP_HIGHZ 6'h03
`define JTBS_OP_EXTEST_TRAIN 6'h3C
`define JTBS_OP_EXTEST_PULSE 6'h3D
`define JTBS_OP_CLAMP 6'h3E
`define JTBS_OP_BYPASS 6'h3F
`define JTBS_ID_WIDTH 32
// Arbitrary identification value, bit 0 set as the standard asks
`define JTBS_IDCODE_DEFAULT 32'h0ABC_D001
`define JTBS_TMS_RESET_CYCLES 5
`endif

// >>> design/jtbs_chain_if.sv
// Carrier between the TAP controller and the boundary chain
interface jtbs_chain_if #(parameter int LEN = 24);
	logic captureEn;
	logic shiftEn;
	logic updateEn;
	logic tdi;
	logic [LEN-1:0] capVal;
	logic chainOut;
	logic [LEN-1:0] updVal;
	modport tap (output captureEn, output shiftEn, output updateEn, output tdi,
		output capVal, input chainOut, input updVal);
	modport chain (input captureEn, input shiftEn, input updateEn, input tdi,
		input capVal, output chainOut, output updVal);
endinterface : jtbs_chain_if

// >>> design/jtbs_pkg.sv
// Types for the test access port and boundary chain
package jtbs_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
	} jtbs_tap_state_t;
	typedef enum logic [1:0] {
		DR_BYPASS, DR_IDCODE, DR_BOUNDARY
	} jtbs_dr_sel_t;
endpackage : jtbs_pkg

// >>> design/jtbs_tap.sv
// TAP controller, register decode and boundary pin control
`include "jtbs_cfg.svh"

module jtbs_tap #(
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 4,
	parameter int NUM_BIDIR = 4,
	parameter logic [`JTBS_ID_WIDTH-1:0] IDCODE_VALUE = `JTBS_IDCODE_DEFAULT
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Test port
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoEn,
	// Input-only pins
	input wire logic [NUM_IN-1:0] inPad,
	// Output pins
	input wire logic [NUM_OUT-1:0] outCore,
	output logic [NUM_OUT-1:0] outPad,
	output logic [NUM_OUT-1:0] outPadEn,
	// Two-way pins
	input wire logic [NUM_BIDIR-1:0] bidCoreOut,
	input wire logic [NUM_BIDIR-1:0] bidCoreOe,
	input wire logic [NUM_BIDIR-1:0] bidPadIn,
	output logic [NUM_BIDIR-1:0] bidPadOut,
	output logic [NUM_BIDIR-1:0] bidPadOe
);
	import jtbs_pkg::*;

	localparam int LEN = NUM_IN + NUM_OUT + 2 * NUM_BIDIR;
	localparam int RAW = NUM_IN + NUM_OUT + 3 * NUM_BIDIR;
	localparam int IRW = `JTBS_IR_WIDTH;
	localparam int IDW = `JTBS_ID_WIDTH;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		jtbs_tap_state_t state;
		logic [IRW-1:0] irSh;
		logic [IRW-1:0] ir;
		logic byp;
		logic [IDW-1:0] idSh;
		logic [RAW-1:0] pinS1;
		logic [RAW-1:0] pinS2;
	} jtbs_tck_t;

	typedef struct packed {
		logic tdo;
		logic tdoEn;
	} jtbs_neg_t;

	typedef struct packed {
		logic [LEN-1:0] updS1;
		logic [LEN-1:0] updS2;
		logic [1:0] modeS1;
		logic [1:0] modeS2;
		logic [NUM_OUT-1:0] outPad;
		logic [NUM_OUT-1:0] outPadEn;
		logic [NUM_BIDIR-1:0] bidPadOut;
		logic [NUM_BIDIR-1:0] bidPadOe;
	} jtbs_sys_t;

	jtbs_tck_t t;
	jtbs_tck_t next_t;
	jtbs_neg_t n;
	jtbs_neg_t next_n;
	jtbs_sys_t s;
	jtbs_sys_t next_s;

	jtbs_chain_if #(.LEN(LEN)) bc ();

	jtbs_dr_sel_t drSel;
	logic extestMode;
	logic driveBoundary;
	logic forceOff;
	logic [LEN-1:0] capVal;

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	always_comb
	begin
		extestMode = 1'b0;
		driveBoundary = 1'b0;
		forceOff = 1'b0;
		drSel = DR_BYPASS;
		unique case (t.ir)
			`JTBS_OP_EXTEST, `JTBS_OP_EXTEST_TRAIN, `JTBS_OP_EXTEST_PULSE:
			begin
				extestMode = 1'b1;
				driveBoundary = 1'b1;
				drSel = DR_BOUNDARY;
			end
			`JTBS_OP_SAMPLE:
				drSel = DR_BOUNDARY;
			`JTBS_OP_IDCODE:
				drSel = DR_IDCODE;
			`JTBS_OP_HIGHZ:
				forceOff = 1'b1;
			`JTBS_OP_CLAMP:
				driveBoundary = 1'b1;
			default:
				drSel = DR_BYPASS;
		endcase
	end

	// ----------------------------------------
	// Capture values for the chain
	// ----------------------------------------
	always_comb
	begin
		capVal = '0;
		for (int i = 0; i < NUM_IN; i++)
			capVal[i] = t.pinS2[i];
		for (int i = 0; i < NUM_OUT; i++)
			capVal[NUM_IN + i] = t.pinS2[NUM_IN + i];
		for (int i = 0; i < NUM_BIDIR; i++)
		begin
			capVal[NUM_IN + NUM_OUT + 2 * i] = t.pinS2[NUM_IN + NUM_OUT + 3 * i + 1];
			capVal[NUM_IN + NUM_OUT + 2 * i + 1] =
				(extestMode || !t.pinS2[NUM_IN + NUM_OUT + 3 * i + 1]) ?
				t.pinS2[NUM_IN + NUM_OUT + 3 * i + 2] : t.pinS2[NUM_IN + NUM_OUT + 3 * i];
		end
	end

	assign bc.captureEn = (t.state == CAP_DR) && (drSel == DR_BOUNDARY);
	assign bc.shiftEn = (t.state == SHIFT_DR) && (drSel == DR_BOUNDARY);
	assign bc.updateEn = (t.state == UPD_DR) && (drSel == DR_BOUNDARY);
	assign bc.tdi = tdi;
	assign bc.capVal = capVal;

	jtbs_bscan_chain #(.LEN(LEN)) uChain (
		.tck(tck),
		.trst_b(trst_b),
		.bc(bc.chain)
	);

	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	always_comb
	begin
		next_t = t;
		next_t.pinS1 = {bidPadIn[0 +: NUM_BIDIR], bidCoreOe, bidCoreOut, outCore, inPad};
		for (int i = 0; i < NUM_BIDIR; i++)
			next_t.pinS1[NUM_IN + NUM_OUT + 3 * i +: 3] = {bidPadIn[i], bidCoreOe[i], bidCoreOut[i]};
		next_t.pinS2 = t.pinS1;
		unique case (t.state)
			TAP_RESET: next_t.state = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: next_t.state = tms ? SEL_DR : TAP_IDLE;
			SEL_DR: next_t.state = tms ? SEL_IR : CAP_DR;
			CAP_DR: next_t.state = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: next_t.state = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: next_t.state = tms ? UPD_DR : PAUSE_DR;
			PAUSE_DR: next_t.state = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: next_t.state = tms ? UPD_DR : SHIFT_DR;
			UPD_DR: next_t.state = tms ? SEL_DR : TAP_IDLE;
			SEL_IR: next_t.state = tms ? TAP_RESET : CAP_IR;
			CAP_IR: next_t.state = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: next_t.state = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: next_t.state = tms ? UPD_IR : PAUSE_IR;
			PAUSE_IR: next_t.state = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: next_t.state = tms ? UPD_IR : SHIFT_IR;
			UPD_IR: next_t.state = tms ? SEL_DR : TAP_IDLE;
		endcase
		unique case (t.state)
			TAP_RESET: next_t.ir = `JTBS_OP_IDCODE;
			CAP_IR: next_t.irSh = `JTBS_IR_CAPTURE;
			SHIFT_IR: next_t.irSh = {tdi, t.irSh[IRW-1:1]};
			UPD_IR: next_t.ir = t.irSh;
			CAP_DR:
			begin
				next_t.byp = 1'b0;
				next_t.idSh = IDCODE_VALUE;
			end
			SHIFT_DR:
			begin
				next_t.byp = tdi;
				next_t.idSh = {tdi, t.idSh[IDW-1:1]};
			end
			default: next_t.byp = t.byp;
		endcase
	end

	always_ff @(posedge tck or negedge trst_b)
	begin
		if (!trst_b)
		begin
			t <= '0;
			t.state <= TAP_RESET;
			t.ir <= `JTBS_OP_IDCODE;
		end
		else
			t <= next_t;
	end

	// ----------------------------------------
	// Serial output on the falling edge
	// ----------------------------------------
	always_comb
	begin
		next_n.tdoEn = (t.state == SHIFT_DR) || (t.state == SHIFT_IR);
		next_n.tdo = 1'b0;
		if (t.state == SHIFT_IR)
			next_n.tdo = t.irSh[0];
		else if (drSel == DR_BOUNDARY)
			next_n.tdo = bc.chainOut;
		else if (drSel == DR_IDCODE)
			next_n.tdo = t.idSh[0];
		else
			next_n.tdo = t.byp;
	end

	always_ff @(negedge tck or negedge trst_b)
	begin
		if (!trst_b)
			n <= '0;
		else
			n <= next_n;
	end

	assign tdo = n.tdo;
	assign tdoEn = n.tdoEn;

	// ----------------------------------------
	// Pin control in the system domain
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.updS1 = bc.updVal;
		next_s.updS2 = s.updS1;
		next_s.modeS1 = {forceOff, driveBoundary};
		next_s.modeS2 = s.modeS1;
		for (int i = 0; i < NUM_OUT; i++)
		begin
			next_s.outPad[i] = s.modeS2[0] ? s.updS2[NUM_IN + i] : outCore[i];
			next_s.outPadEn[i] = !s.modeS2[1];
		end
		for (int i = 0; i < NUM_BIDIR; i++)
		begin
			next_s.bidPadOut[i] = s.modeS2[0] ? s.updS2[NUM_IN + NUM_OUT + 2 * i + 1] :
				bidCoreOut[i];
			next_s.bidPadOe[i] = s.modeS2[1] ? 1'b0 :
				(s.modeS2[0] ? s.updS2[NUM_IN + NUM_OUT + 2 * i] : bidCoreOe[i]);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= '0;
		else
			s <= next_s;
	end

	assign outPad = s.outPad;
	assign outPadEn = s.outPadEn;
	assign bidPadOut = s.bidPadOut;
	assign bidPadOe = s.bidPadOe;
endmodule : jtbs_tap

// >>> dv/jtbs_tap_bench.sv
// Testbench for the test access port and boundary chain
`include "jtbs_cfg.svh"
module jtbs_tap_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sysClk = 1'b0;
	logic rstB = 1'b0;
	logic trstB = 1'b0;
	logic tck, tms, tdi, tdo, tdoEn, tdoLine;
	logic [3:0] inPad, outCore, outPad, outPadEn, bidCoreOut, bidCoreOe, bidExt;
	logic [3:0] bidPadIn, bidPadOut, bidPadOe;
	logic [31:0] rnd = 32'h0000A8F5;
	logic [63:0] got;
	logic [15:0] pat;
	logic [5:0] ops [5] = '{`JTBS_OP_EXTEST, `JTBS_OP_EXTEST_TRAIN, `JTBS_OP_EXTEST_PULSE,
		`JTBS_OP_CLAMP, `JTBS_OP_HIGHZ};
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	assign tdoLine = tdoEn ? tdo : ~tdo;
	assign bidPadIn = bidPadOe & bidPadOut | ~bidPadOe & bidExt;
	initial
	begin
		forever #5 sysClk = ~sysClk;
	end
	jtbs_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));
	jtbs_tap dut (.sys_clk(sysClk), .rst_b(rstB), .tck(tck), .trst_b(trstB), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .inPad(inPad), .outCore(outCore), .outPad(outPad),
		.outPadEn(outPadEn), .bidCoreOut(bidCoreOut), .bidCoreOe(bidCoreOe),
		.bidPadIn(bidPadIn), .bidPadOut(bidPadOut), .bidPadOe(bidPadOe));
	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [15:0] chainExp();
		logic [15:0] c;
		c[7:0] = {outCore, inPad};
		for (int i = 0; i < 4; i++)
			c[8 + 2 * i +: 2] = {bidCoreOe[i] ? bidCoreOut[i] : bidExt[i], bidCoreOe[i]};
		return c;
	endfunction : chainExp
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic scan(input logic isIr, input int n, input logic [63:0] d);
		got = '0;
		u_tst.step(1'b1, 1'b0);
		if (isIr)
			u_tst.step(1'b1, 1'b0);
		u_tst.step(1'b0, 1'b0);
		u_tst.step(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			u_tst.step(i == n - 1, d[i]);
			got[i] = u_tst.got;
		end
		u_tst.step(1'b1, 1'b0);
		u_tst.step(1'b0, 1'b0);
	endtask : scan
	always @(posedge sysClk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			errors++;
			test_done();
		end
	end
	// ------------------------------
	// Sequence
	// ------------------------------
	initial
	begin
		{inPad, outCore, bidCoreOut, bidCoreOe, bidExt} = '0;
		repeat (4) @(posedge sysClk);
		@(negedge sysClk);
		rstB = 1'b1;
		trstB = 1'b1;
		u_tst.step(1'b0, 1'b0);
		scan(1'b0, 32, '0);
		check(got[31:0], `JTBS_IDCODE_DEFAULT);
		scan(1'b1, 6, {58'h0, `JTBS_OP_BYPASS});
		check(got[5:0], `JTBS_IR_CAPTURE);
		scan(1'b0, 8, rnd);
		check(got[7:0], {rnd[6:0], 1'b0});
		foreach (ops[k])
		begin
			@(negedge sysClk);
			rnd = xs(rnd);
			{inPad, outCore, bidCoreOut, bidCoreOe, bidExt} = rnd[19:0];
			scan(1'b1, 6, {58'h0, `JTBS_OP_SAMPLE});
			pat = rnd[31:16];
			scan(1'b0, 16, pat);
			check(got[15:0], chainExp());
			scan(1'b1, 6, ops[k]);
			repeat (8) @(negedge sysClk);
			if (ops[k] == `JTBS_OP_HIGHZ)
				check({outPadEn, bidPadOe}, 8'h00);
			else
				check({outPad, outPadEn, bidPadOut, bidPadOe}, {pat[7:4], 4'hF, pat[15],
					pat[13], pat[11], pat[9], pat[14], pat[12], pat[10], pat[8]});
		end
		scan(1'b1, 6, {58'h0, `JTBS_OP_BYPASS});
		u_tst.step(1'b1, 1'b0);
		u_tst.step(1'b0, 1'b0);
		u_tst.step(1'b0, 1'b0);
		#1 check(tdoEn, 1'b1);
		repeat (5) u_tst.step(1'b1, 1'b0);
		#1 check(tdoEn, 1'b0);
		u_tst.step(1'b0, 1'b0);
		scan(1'b0, 32, '0);
		check(got[31:0], `JTBS_IDCODE_DEFAULT);
		scan(1'b1, 6, {58'h0, `JTBS_OP_BYPASS});
		u_tst.step(1'b1, 1'b0);
		u_tst.step(1'b0, 1'b0);
		u_tst.step(1'b0, 1'b0);
		@(negedge sysClk);
		trstB = 1'b0;
		#1 check({tdo, tdoEn}, 2'b00);
		@(negedge sysClk);
		trstB = 1'b1;
		u_tst.step(1'b0, 1'b0);
		scan(1'b0, 32, '0);
		check(got[31:0], `JTBS_IDCODE_DEFAULT);
		test_done();
	end
endmodule : jtbs_tap_bench

// >>> dv/jtbs_tap_chk.sv
// Checker on the test port and pad enables
`include "jtbs_cfg.svh"
module jtbs_tap_chk
	import jtbs_pkg::*;
#(
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 4,
	parameter int NUM_BIDIR = 4,
	parameter logic [`JTBS_ID_WIDTH-1:0] IDCODE_VALUE = `JTBS_IDCODE_DEFAULT
) (
	// Clocks and resets
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic trst_b,
	// Test port and pins
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdoEn,
	input wire logic [NUM_IN-1:0] inPad,
	input wire logic [NUM_OUT-1:0] outPadEn,
	input wire logic [NUM_BIDIR-1:0] bidPadOe
);
	localparam logic [5:0] IRC = `JTBS_IR_CAPTURE;
	jtbs_tap_state_t st;
	logic [5:0] ir;
	logic [5:0] irSh;
	logic [5:0] cnt;
	// ------------------------------
	// Reference state walk
	// ------------------------------
	function automatic jtbs_tap_state_t nxt(jtbs_tap_state_t s, logic m);
		case (s)
			TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE, UPD_DR, UPD_IR: return m ? SEL_DR : TAP_IDLE;
			SEL_DR: return m ? SEL_IR : CAP_DR;
			CAP_DR, SHIFT_DR: return m ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: return m ? UPD_DR : PAUSE_DR;
			PAUSE_DR: return m ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: return m ? UPD_DR : SHIFT_DR;
			SEL_IR: return m ? TAP_RESET : CAP_IR;
			CAP_IR, SHIFT_IR: return m ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: return m ? UPD_IR : PAUSE_IR;
			PAUSE_IR: return m ? EXIT2_IR : PAUSE_IR;
			default: return m ? UPD_IR : SHIFT_IR;
		endcase
	endfunction : nxt
	always_ff @(posedge tck or negedge trst_b)
	begin
		if (!trst_b)
		begin
			st <= TAP_RESET;
			ir <= `JTBS_OP_IDCODE;
			irSh <= 6'h00;
			cnt <= 6'h00;
		end
		else
		begin
			st <= nxt(st, tms);
			cnt <= (st == SHIFT_DR || st == SHIFT_IR) ? cnt + 6'h01 : 6'h00;
			irSh <= (st == SHIFT_IR) ? {tdi, irSh[5:1]} : irSh;
			ir <= (st == UPD_IR) ? irSh : (st == TAP_RESET) ? `JTBS_OP_IDCODE : ir;
		end
	end
	// ------------------------------
	// Assertions
	// ------------------------------
	reset_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!trst_b |-> !tdo && !tdoEn) else $error("tdo active in reset");
	fall_launch_a: assert property (@(posedge sys_clk) disable iff (!trst_b)
		$changed(tdo) || $changed(tdoEn) |-> !tck) else $error("tdo moved with clock high");
	shift_enable_a: assert property (@(posedge tck) disable iff (!trst_b)
		tdoEn == (st == SHIFT_DR || st == SHIFT_IR)) else $error("tdo enable wrong");
	ir_capture_a: assert property (@(posedge tck) disable iff (!trst_b)
		st == SHIFT_IR && cnt < 6'h06 |-> tdo == IRC[cnt]) else $error("ir capture wrong");
	bypass_path_a: assert property (@(posedge tck) disable iff (!trst_b)
		st == SHIFT_DR && $past(st) == SHIFT_DR && ir == `JTBS_OP_BYPASS |-> tdo == $past(tdi))
		else $error("bypass bit wrong");
	idcode_out_a: assert property (@(posedge tck) disable iff (!trst_b)
		st == SHIFT_DR && ir == `JTBS_OP_IDCODE && cnt < 6'h20 |-> tdo == IDCODE_VALUE[cnt[4:0]])
		else $error("identity bit wrong");
	sample_in_a: assert property (@(posedge tck) disable iff (!trst_b)
		st == SHIFT_DR && ir == `JTBS_OP_SAMPLE && cnt < NUM_IN |-> tdo == inPad[cnt])
		else $error("observe cell wrong");
	highz_off_a: assert property (@(posedge tck) disable iff (!trst_b)
		ir == `JTBS_OP_HIGHZ && $past(ir) == `JTBS_OP_HIGHZ |-> outPadEn == '0 && bidPadOe == '0)
		else $error("pads driven in highz");
	cover property (@(posedge tck) st == UPD_IR && irSh == `JTBS_OP_EXTEST);
	cover property (@(posedge tck) st == SHIFT_DR && cnt == 6'h1F);
	cover property (@(posedge tck) disable iff (!trst_b) tms [*5]);
endmodule : jtbs_tap_chk

bind jtbs_tap jtbs_tap_chk #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .NUM_BIDIR(NUM_BIDIR),
	.IDCODE_VALUE(IDCODE_VALUE)) u_chk (.sys_clk, .rst_b, .tck, .trst_b, .tms, .tdi, .tdo,
	.tdoEn, .inPad, .outPadEn, .bidPadOe);

// >>> dv/jtbs_tester.sv
// Tester model that drives the test port
module jtbs_tester (
	// Test port
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ns;
	logic got;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One gated test clock, levels set while low
	task automatic step(input logic m, input logic d);
		#3 tms = m;
		tdi = d;
		#77 tck = 1'b1;
		got = tdo;
		#80 tck = 1'b0;
	endtask : step
endmodule : jtbs_tester
